// ### common/brc_map.svh
// Constants for the boot, reset and clock-select start-up block.
// Assumes inclusion by bare name from the core file.
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH
`define BRC_TRI_LOW 2'h0
`define BRC_TRI_HIGH 2'h1
`define BRC_TRI_FLOAT 2'h2
`define BRC_CLKSEL_XTAL 3'h0
`define BRC_CLKSEL_EXT_BIT 2
`define BRC_INIT_CPU_BIT 0
`define BRC_INIT_DEV_BIT 1
`define BRC_PLL_MULT_19M2 8'h34
`define BRC_PLL_MULT_26M 8'h26
`define BRC_PLL_MULT_38M4 8'h1A
`define BRC_PLL_MULT_52M 8'h13
`define BRC_SOFT_PULSE_CYC 4'h8
`endif

// ### common/brc_pkg.sv
// Types for the boot, reset and clock-select start-up block.
// Does not include the map header; only the core file does.
`default_nettype none
package brc_pkg;
    typedef enum logic [2:0] {
        BRC_BOOT_ADDR_DATA_MUXED,
        BRC_BOOT_USB,
        BRC_BOOT_I2C_USB,
        BRC_BOOT_I2C,
        BRC_BOOT_SPI_USB,
        BRC_BOOT_INVALID
    } brc_boot_t;
    typedef enum logic [2:0] {
        BRC_CLK_XTAL_19M2,
        BRC_CLK_EXT_19M2,
        BRC_CLK_EXT_26M,
        BRC_CLK_EXT_38M4,
        BRC_CLK_EXT_52M,
        BRC_CLK_INVALID
    } brc_clk_t;
    typedef enum logic [1:0] {
        BRC_ST_HOLD,
        BRC_ST_SAMPLE,
        BRC_ST_RUN,
        BRC_ST_CPU_RST
    } brc_state_t;
endpackage
`default_nettype wire

// ### core/brc_core.sv
// Start-up control: strap decode, hard reset and two kinds of soft reset.
// Assumes strap levels arrive pre-resolved as low/high/float codes.
`default_nettype none
`include "brc_map.svh"
module brc_core
    import brc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Straps: boot pins two bits each (low, high or float), clock pins one bit each
    input wire logic [5:0] boot_select_strap,
    input wire logic [2:0] clock_select_strap,
    // Processor write to the init control register
    input wire logic init_control_wr,
    input wire logic [1:0] init_control_reg,
    // Boot handshake
    input wire logic boot_fail,
    // Results
    output var brc_boot_t boot_source,
    output logic usb_fallback_en,
    output var brc_clk_t clock_source,
    output logic osc_enable,
    output logic ext_clk_select,
    output logic [7:0] pll_mult,
    output logic io_tristate,
    output logic boot_start,
    output logic boot_io_config,
    output logic cpu_reset,
    output logic mem_clear
);
    brc_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    brc_boot_t boot_ff, nxt_boot;
    brc_clk_t clk_ff, nxt_clk;
    logic fb_ff, nxt_fb;
    logic osc_ff, nxt_osc;
    logic ext_ff, nxt_ext;
    logic [7:0] mult_ff, nxt_mult;
    logic tri_ff, nxt_tri;
    logic start_ff, nxt_start;
    logic iocfg_ff, nxt_iocfg;
    logic cpur_ff, nxt_cpur;
    logic memc_ff, nxt_memc;
    brc_boot_t dec_boot;
    brc_clk_t dec_clk;
    logic [7:0] dec_mult;
    logic [2:0] strap_hi;
    logic [2:0] strap_lo;
    logic [2:0] strap_fl;

    // Per-pin classification of the tri-level boot straps.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_strap
            assign strap_lo[gi] = boot_select_strap[2*gi +: 2] == `BRC_TRI_LOW;
            assign strap_hi[gi] = boot_select_strap[2*gi +: 2] == `BRC_TRI_HIGH;
            assign strap_fl[gi] = boot_select_strap[2*gi +: 2] == `BRC_TRI_FLOAT;
        end
    endgenerate

    always_comb
    begin
        dec_boot = BRC_BOOT_INVALID;
        if (strap_fl[2] && strap_lo[1] && strap_lo[0])
            dec_boot = BRC_BOOT_ADDR_DATA_MUXED;
        else if (strap_fl[2] && strap_hi[1] && strap_hi[0])
            dec_boot = BRC_BOOT_USB;
        else if (strap_fl[2] && strap_hi[1] && strap_fl[0])
            dec_boot = BRC_BOOT_I2C_USB;
        else if (strap_hi[2] && strap_fl[1] && strap_fl[0])
            dec_boot = BRC_BOOT_I2C;
        else if (strap_lo[2] && strap_fl[1] && strap_hi[0])
            dec_boot = BRC_BOOT_SPI_USB;
    end

    always_comb
    begin
        dec_clk = BRC_CLK_INVALID;
        dec_mult = `BRC_PLL_MULT_19M2;
        if (clock_select_strap == `BRC_CLKSEL_XTAL)
            dec_clk = BRC_CLK_XTAL_19M2;
        else if (clock_select_strap[`BRC_CLKSEL_EXT_BIT])
        begin
            case (clock_select_strap[1:0])
                2'h0: dec_clk = BRC_CLK_EXT_19M2;
                2'h1: dec_clk = BRC_CLK_EXT_26M;
                2'h2: dec_clk = BRC_CLK_EXT_38M4;
                default: dec_clk = BRC_CLK_EXT_52M;
            endcase
        end
        case (dec_clk)
            BRC_CLK_EXT_26M: dec_mult = `BRC_PLL_MULT_26M;
            BRC_CLK_EXT_38M4: dec_mult = `BRC_PLL_MULT_38M4;
            BRC_CLK_EXT_52M: dec_mult = `BRC_PLL_MULT_52M;
            default: dec_mult = `BRC_PLL_MULT_19M2;
        endcase
    end

    // The power-on hold time is the board's duty; the block just waits on rst_n.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_boot = boot_ff;
        nxt_clk = clk_ff;
        nxt_fb = fb_ff;
        nxt_osc = osc_ff;
        nxt_ext = ext_ff;
        nxt_mult = mult_ff;
        nxt_tri = tri_ff;
        nxt_start = 1'b0;
        nxt_iocfg = iocfg_ff;
        nxt_cpur = cpur_ff;
        nxt_memc = 1'b0;
        case (state_ff)
            BRC_ST_HOLD:
            begin
                nxt_tri = 1'b1;
                nxt_iocfg = 1'b0;
                nxt_cpur = 1'b1;
                if (cnt_ff != 4'h0)
                    nxt_cnt = cnt_ff - 4'h1;
                else
                    nxt_state = BRC_ST_SAMPLE;
            end
            BRC_ST_SAMPLE:
            begin
                nxt_boot = dec_boot;
                nxt_clk = dec_clk;
                nxt_mult = dec_mult;
                nxt_osc = dec_clk == BRC_CLK_XTAL_19M2;
                nxt_ext = clock_select_strap[`BRC_CLKSEL_EXT_BIT];
                nxt_fb = dec_boot == BRC_BOOT_I2C_USB || dec_boot == BRC_BOOT_SPI_USB;
                nxt_tri = 1'b0;
                nxt_iocfg = 1'b1;
                nxt_start = 1'b1;
                nxt_cpur = 1'b0;
                nxt_state = BRC_ST_RUN;
            end
            BRC_ST_RUN:
            begin
                // Fallback is armed at sampling; a failure only matters when it is.
                if (boot_fail && fb_ff)
                    nxt_boot = BRC_BOOT_USB;
                if (init_control_wr && init_control_reg[`BRC_INIT_DEV_BIT])
                begin
                    // Whole-device reset wins over a simultaneous processor reset.
                    nxt_state = BRC_ST_HOLD;
                    nxt_cnt = `BRC_SOFT_PULSE_CYC;
                    nxt_tri = 1'b1;
                    nxt_iocfg = 1'b0;
                    nxt_cpur = 1'b1;
                    nxt_memc = 1'b1;
                end
                else if (init_control_wr && init_control_reg[`BRC_INIT_CPU_BIT])
                begin
                    nxt_state = BRC_ST_CPU_RST;
                    nxt_cnt = `BRC_SOFT_PULSE_CYC;
                    nxt_cpur = 1'b1;
                end
            end
            BRC_ST_CPU_RST:
            begin
                if (cnt_ff != 4'h0)
                    nxt_cnt = cnt_ff - 4'h1;
                else
                begin
                    nxt_cpur = 1'b0;
                    nxt_state = BRC_ST_RUN;
                end
            end
            default:
                nxt_state = BRC_ST_HOLD;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= BRC_ST_HOLD;
            cnt_ff <= 4'h0;
            boot_ff <= BRC_BOOT_INVALID;
            clk_ff <= BRC_CLK_INVALID;
            fb_ff <= 1'b0;
            osc_ff <= 1'b0;
            ext_ff <= 1'b0;
            mult_ff <= `BRC_PLL_MULT_19M2;
            tri_ff <= 1'b1;
            start_ff <= 1'b0;
            iocfg_ff <= 1'b0;
            cpur_ff <= 1'b1;
            memc_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            boot_ff <= nxt_boot;
            clk_ff <= nxt_clk;
            fb_ff <= nxt_fb;
            osc_ff <= nxt_osc;
            ext_ff <= nxt_ext;
            mult_ff <= nxt_mult;
            tri_ff <= nxt_tri;
            start_ff <= nxt_start;
            iocfg_ff <= nxt_iocfg;
            cpur_ff <= nxt_cpur;
            memc_ff <= nxt_memc;
        end
    end

    assign boot_source = boot_ff;
    assign usb_fallback_en = fb_ff;
    assign clock_source = clk_ff;
    assign osc_enable = osc_ff;
    assign ext_clk_select = ext_ff;
    assign pll_mult = mult_ff;
    assign io_tristate = tri_ff;
    assign boot_start = start_ff;
    assign boot_io_config = iocfg_ff;
    assign cpu_reset = cpur_ff;
    assign mem_clear = memc_ff;

    chk_tri_in_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_HOLD |-> io_tristate) else $error("io not tristated in hold");
    chk_release_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_SAMPLE |=> boot_start && !io_tristate && boot_io_config)
        else $error("boot not started after release");
    chk_straps_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_RUN && $past(state_ff) == BRC_ST_RUN && !boot_fail
        |-> $stable(clock_source) && $stable(pll_mult)) else $error("straps changed");
    chk_dev_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_RUN && init_control_wr && init_control_reg[1]
        |=> io_tristate && mem_clear ##1 io_tristate[*8]) else $error("device reset");
    chk_cpu_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_RUN && init_control_wr && init_control_reg == 2'h1
        |=> cpu_reset && !mem_clear && !io_tristate ##9 !cpu_reset)
        else $error("cpu reset");
    chk_xtal_osc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_SAMPLE && clock_select_strap == 3'h0
        |=> osc_enable && !ext_clk_select) else $error("crystal not enabled");
    chk_ext_52: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_SAMPLE && clock_select_strap == 3'h7
        |=> clock_source == BRC_CLK_EXT_52M && pll_mult == 8'h13) else $error("52 MHz");
    chk_usb_strap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_SAMPLE && boot_select_strap == 6'h25
        |=> boot_source == BRC_BOOT_USB && !usb_fallback_en) else $error("F11 decode");
    chk_spi_fallback: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_SAMPLE && boot_select_strap == 6'h09
        |=> boot_source == BRC_BOOT_SPI_USB && usb_fallback_en) else $error("0F1 decode");
    chk_fallback_usb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == BRC_ST_RUN && boot_fail && usb_fallback_en
        |=> boot_source == BRC_BOOT_USB) else $error("no usb fallback");
endmodule
`default_nettype wire

// ### tb/brc_board.sv
// Board model: strap resistors and the external reset source.
// Assumes the bench sets strap levels and requests resets in step with clk_sys.
`default_nettype none
module brc_board #(
    parameter int HOLD_CYC = 16
) (
    // Clock and requests from the bench
    input wire logic clk_sys,
    input wire logic rst_req,
    input wire logic [5:0] boot_lvl,
    input wire logic [2:0] clk_lvl,
    // Pins seen by the device
    output logic rst_n,
    output logic [5:0] boot_select_strap,
    output logic [2:0] clock_select_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial rst_n = 1'b0;
    // The minimum hold is scaled down from the real one so that runs stay short.
    always @(posedge clk_sys)
    begin
        if (rst_req)
        begin
            cnt <= 0;
            rst_n <= 1'b0;
        end
        else if (cnt < HOLD_CYC)
            cnt <= cnt + 1;
        else
            rst_n <= 1'b1;
    end
    assign boot_select_strap = boot_lvl;
    assign clock_select_strap = clk_lvl;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Bench for the start-up block: strap decode, hard reset and soft resets.
// Assumes brc_pkg and the board model are compiled before this file.
`default_nettype none
module tb_top
    import brc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_req = 1'b1;
    logic [5:0] boot_lvl = 6'h25;
    logic [2:0] clk_lvl = 3'h0;
    logic init_control_wr = 1'b0;
    logic [1:0] init_control_reg = 2'h0;
    logic boot_fail = 1'b0;
    wire logic rst_n;
    wire logic [5:0] boot_select_strap;
    wire logic [2:0] clock_select_strap;
    brc_boot_t boot_source;
    brc_clk_t clock_source;
    logic usb_fallback_en, osc_enable, ext_clk_select, io_tristate;
    logic boot_start, boot_io_config, cpu_reset, mem_clear;
    logic [7:0] pll_mult;
    int miscompares = 0;
    int n_compared = 0;
    always #2.5 clk_sys = ~clk_sys;
    brc_board #(.HOLD_CYC(16)) board (.clk_sys(clk_sys), .rst_req(rst_req),
        .boot_lvl(boot_lvl), .clk_lvl(clk_lvl), .rst_n(rst_n),
        .boot_select_strap(boot_select_strap), .clock_select_strap(clock_select_strap));
    brc_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .boot_select_strap(boot_select_strap),
        .clock_select_strap(clock_select_strap), .init_control_wr(init_control_wr),
        .init_control_reg(init_control_reg), .boot_fail(boot_fail),
        .boot_source(boot_source), .usb_fallback_en(usb_fallback_en),
        .clock_source(clock_source), .osc_enable(osc_enable),
        .ext_clk_select(ext_clk_select), .pll_mult(pll_mult), .io_tristate(io_tristate),
        .boot_start(boot_start), .boot_io_config(boot_io_config),
        .cpu_reset(cpu_reset), .mem_clear(mem_clear));
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t %s got %0h want %0h", $time, msg, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Outputs are only stable two edges after release, when straps are taken.
    task automatic hard_rst(input logic [5:0] b, input logic [2:0] c);
        int i;
        @(posedge clk_sys);
        rst_req <= 1'b1;
        boot_lvl <= b;
        clk_lvl <= c;
        tick(2);
        chk(io_tristate, 1'b1, "tri in reset");
        chk(cpu_reset, 1'b1, "cpu in reset");
        @(posedge clk_sys);
        rst_req <= 1'b0;
        for (i = 0; i < 40 && rst_n !== 1'b1; i++)
            tick(1);
        if (rst_n !== 1'b1)
        begin
            miscompares++;
            $display("BAD %0t reset never released", $time);
            test_done();
        end
        tick(2);
        chk(boot_start, 1'b1, "boot start");
        chk(io_tristate, 1'b0, "tri off");
        chk(boot_io_config, 1'b1, "io config");
        tick(1);
        chk(boot_start, 1'b0, "boot start pulse");
    endtask
    task automatic wr_init(input logic [1:0] d);
        @(posedge clk_sys);
        init_control_wr <= 1'b1;
        init_control_reg <= d;
        @(posedge clk_sys);
        init_control_wr <= 1'b0;
        // Return just after the taking edge, so that one-cycle answers are still seen.
        #1;
    endtask
    task automatic t_decode();
        logic [5:0] bc [6] = '{6'h20, 6'h25, 6'h26, 6'h1A, 6'h09, 6'h00};
        brc_boot_t eb [6] = '{BRC_BOOT_ADDR_DATA_MUXED, BRC_BOOT_USB, BRC_BOOT_I2C_USB,
            BRC_BOOT_I2C, BRC_BOOT_SPI_USB, BRC_BOOT_INVALID};
        logic [2:0] cc [6] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1};
        brc_clk_t ec [6] = '{BRC_CLK_XTAL_19M2, BRC_CLK_EXT_19M2, BRC_CLK_EXT_26M,
            BRC_CLK_EXT_38M4, BRC_CLK_EXT_52M, BRC_CLK_INVALID};
        logic [7:0] pm [6] = '{8'h34, 8'h34, 8'h26, 8'h1A, 8'h13, 8'h34};
        logic [5:0] fb = 6'h14;
        for (int i = 0; i < 6; i++)
        begin
            hard_rst(bc[i], cc[i]);
            chk(boot_source, eb[i], "boot source");
            chk(usb_fallback_en, fb[i], "fallback");
            chk(clock_source, ec[i], "clock source");
            chk(osc_enable, i == 0, "osc");
            chk(ext_clk_select, cc[i][2], "ext clk");
            chk(pll_mult, pm[i], "pll");
        end
    endtask
    // A write during the processor reset must be dropped, and straps must not be retaken.
    task automatic t_cpu_rst();
        hard_rst(6'h26, 3'h4);
        @(posedge clk_sys);
        boot_lvl <= 6'h25;
        clk_lvl <= 3'h7;
        wr_init(2'h1);
        chk(cpu_reset, 1'b1, "cpu rst");
        chk(mem_clear, 1'b0, "mem kept");
        wr_init(2'h2);
        chk(io_tristate, 1'b0, "write refused");
        tick(6);
        chk(cpu_reset, 1'b1, "cpu rst held");
        tick(1);
        chk(cpu_reset, 1'b0, "cpu rst end");
        chk(boot_source, BRC_BOOT_I2C_USB, "no resample");
        chk(pll_mult, 8'h34, "pll kept");
    endtask
    task automatic t_dev_rst();
        wr_init(2'h3);
        chk(io_tristate, 1'b1, "dev tri");
        chk(mem_clear, 1'b1, "mem clear");
        chk(cpu_reset, 1'b1, "dev cpu");
        chk(boot_io_config, 1'b0, "dev io cfg");
        tick(1);
        chk(mem_clear, 1'b0, "mem clear pulse");
        tick(8);
        chk(io_tristate, 1'b1, "dev tri held");
        tick(1);
        chk(boot_start, 1'b1, "reboot");
        chk(io_tristate, 1'b0, "dev tri off");
        chk(boot_source, BRC_BOOT_USB, "resampled");
        chk(pll_mult, 8'h13, "pll resampled");
    endtask
    task automatic t_fail(input logic [5:0] b, input brc_boot_t exp);
        hard_rst(b, 3'h0);
        @(posedge clk_sys);
        boot_fail <= 1'b1;
        @(posedge clk_sys);
        boot_fail <= 1'b0;
        tick(1);
        chk(boot_source, exp, "after fail");
    endtask
    initial
    begin
        tick(16);
        t_decode();
        t_cpu_rst();
        t_dev_rst();
        t_fail(6'h1A, BRC_BOOT_I2C);
        t_fail(6'h09, BRC_BOOT_USB);
        t_fail(6'h26, BRC_BOOT_USB);
        test_done();
    end
endmodule
`default_nettype wire
